/* File: shared/dswb_pkg.sv */
package dswb_pkg;
    // Status word bit positions
    localparam int unsigned SW_CTRL_READY  = 0;
    localparam int unsigned SW_DRIVE_READY = 1;
    localparam int unsigned SW_ENABLE      = 2;
    localparam int unsigned SW_TRIP        = 3;
    localparam int unsigned SW_ON2         = 4;
    localparam int unsigned SW_ON3         = 5;
    localparam int unsigned SW_START_INH   = 6;
    localparam int unsigned SW_WARNING     = 7;
    localparam int unsigned SW_SPEED_MATCH = 8;
    localparam int unsigned SW_BUS_CTRL    = 9;
    localparam int unsigned SW_FREQ_OK     = 10;
    localparam int unsigned SW_IN_OPER     = 11;
    localparam int unsigned SW_AUTOSTART   = 12;
    localparam int unsigned SW_VOLT_EXC    = 13;
    localparam int unsigned SW_TORQ_EXC    = 14;
    localparam int unsigned SW_TIMER_EXC   = 15;

    // Command word bit positions
    localparam int unsigned CW_ON1        = 0;
    localparam int unsigned CW_ON2        = 1;
    localparam int unsigned CW_ON3        = 2;
    localparam int unsigned CW_RESET      = 7;
    localparam int unsigned CW_DATA_VALID = 10;

    localparam int unsigned WORD_W = 16;

    // Register map (byte offsets)
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_COMMAND = 8'h04;
    localparam logic [7:0] ADDR_CONFIG  = 8'h08;

    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    localparam logic [15:0] CMD_RESET_V  = 16'h0000;
    localparam logic        CFG_RESET_V  = 1'b1;
    localparam logic [15:0] CFG_MASK     = 16'h0001;
endpackage

/* File: verilog/dswb_top.sv */
`timescale 1ns/1ns
// Functional notes
// - Bit0 ready unless off command or trip
// - Bit1 as bit0 plus power supplied
// - Bit2 set only when on and untripped
// - Bit3 trip latched until reset edge
// - Bit4 mirrors command bit 1
// - Bit5 mirrors command bit 2
// - Bit6 inhibit set on ack/off2/off3/power-up
// - Inhibit clears on bit0 low, 1,2,10 high
// - Bit7 follows any warning
// - Bit8 set when speed matches reference
// - Bit9 bus control unless stop key/local
// - Bit10 set when frequency within limits
// - Bit11 start present or frequency nonzero
// - Bit12 overload halt without trip
// - Bit13 DC link voltage out of range
// - Bit14 either torque limit exceeded
// - Bit15 either thermal timer over limit
// - Status word reported, master only reads
// - Command ignored while data-valid bit low
// - Link loss forces whole word zero
module dswb_top
    import dswb_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // Supervision conditions, asynchronous to core_clk
    input  wire logic              trip_event,
    input  wire logic              power_supplied,
    input  wire logic              warning_any,
    input  wire logic              speed_at_ref,
    input  wire logic              panel_stop,
    input  wire logic              local_ref_site,
    input  wire logic              freq_in_limits,
    input  wire logic              start_cmd,
    input  wire logic              freq_nonzero,
    input  wire logic              overload_halt,
    input  wire logic              dc_volt_fault,
    input  wire logic              torque_exceeded,
    input  wire logic              thermal_exceeded,
    input  wire logic              link_lost,
    // Status outputs
    output logic      [15:0]       drive_status_word,
    output logic                   start_accepted
);
    localparam int unsigned NSYNC = 14;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] s3;
        logic [NSYNC-1:0] filt;
        logic [15:0]      cmd;
        logic             profile_mode;
        logic             trip;
        logic             inhibit;
        logic             pwr_seen;
        logic             rst_prev;
        logic             on2_prev;
        logic             on3_prev;
        logic [15:0]      status;
        logic [15:0]      rdata;
    } dswb_state_t;

    dswb_state_t st_q;
    dswb_state_t st_d;

    function automatic logic cmd_on_all(input logic [15:0] w);
        cmd_on_all = w[CW_ON1] & w[CW_ON2] & w[CW_ON3];
    endfunction

    logic [NSYNC-1:0] raw_in;
    assign raw_in = {link_lost, thermal_exceeded, torque_exceeded, dc_volt_fault,
                     overload_halt, freq_nonzero, start_cmd, freq_in_limits,
                     local_ref_site, panel_stop, speed_at_ref, warning_any,
                     power_supplied, trip_event};

    logic f_trip;
    logic f_pwr;
    logic f_warn;
    logic f_speed;
    logic f_stop;
    logic f_local;
    logic f_freq;
    logic f_start;
    logic f_fnz;
    logic f_ovl;
    logic f_volt;
    logic f_torq;
    logic f_therm;
    logic f_lost;
    assign {f_lost, f_therm, f_torq, f_volt, f_ovl, f_fnz, f_start, f_freq,
            f_local, f_stop, f_speed, f_warn, f_pwr, f_trip} = st_q.filt;

    logic       cmd_wr;
    logic       cmd_valid;
    logic       rst_edge;
    logic       clr_inhibit;
    logic       set_inhibit;
    logic [15:0] word;

    assign cmd_wr    = reg_wr && (reg_addr == ADDR_COMMAND);
    // Invalid words are dropped so the last valid command keeps acting
    assign cmd_valid = cmd_wr && reg_wdata[CW_DATA_VALID];

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = raw_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Held while stages two and three disagree, so a single-cycle glitch never reaches the word
        st_d.filt = (st_q.s2 & st_q.s3) | (st_q.filt & (st_q.s2 ^ st_q.s3));
        if (cmd_valid)
        begin
            st_d.cmd = reg_wdata;
        end
        if (reg_wr && (reg_addr == ADDR_CONFIG))
        begin
            st_d.profile_mode = |(reg_wdata & CFG_MASK);
        end

        st_d.rst_prev = st_q.cmd[CW_RESET];
        st_d.on2_prev = st_q.cmd[CW_ON2];
        st_d.on3_prev = st_q.cmd[CW_ON3];
        rst_edge = st_q.cmd[CW_RESET] && !st_q.rst_prev;

        // Trip latches; a fresh trip beats a simultaneous reset
        if (f_trip)
        begin
            st_d.trip = 1'b1;
        end
        else if (rst_edge)
        begin
            st_d.trip = 1'b0;
        end

        st_d.pwr_seen = f_pwr;
        set_inhibit = (rst_edge && st_q.trip)
                    || (!st_q.cmd[CW_ON2] && st_q.on2_prev)
                    || (!st_q.cmd[CW_ON3] && st_q.on3_prev)
                    || (f_pwr && !st_q.pwr_seen);
        clr_inhibit = !st_q.cmd[CW_ON1] && st_q.cmd[CW_ON2]
                    && st_q.cmd[CW_ON3] && st_q.cmd[CW_DATA_VALID];
        if (!st_q.profile_mode)
        begin
            st_d.inhibit = 1'b0;
        end
        else if (set_inhibit)
        begin
            st_d.inhibit = 1'b1;
        end
        else if (clr_inhibit)
        begin
            st_d.inhibit = 1'b0;
        end

        word = WORD_ZERO;
        word[SW_CTRL_READY]  = cmd_on_all(st_q.cmd) && !st_q.trip;
        word[SW_DRIVE_READY] = cmd_on_all(st_q.cmd) && !st_q.trip && f_pwr;
        word[SW_ENABLE]      = cmd_on_all(st_q.cmd) && !st_q.trip;
        word[SW_TRIP]        = st_q.trip;
        word[SW_ON2]         = st_q.cmd[CW_ON2];
        word[SW_ON3]         = st_q.cmd[CW_ON3];
        word[SW_START_INH]   = st_q.inhibit;
        word[SW_WARNING]     = f_warn;
        word[SW_SPEED_MATCH] = f_speed;
        word[SW_BUS_CTRL]    = !f_stop && !f_local;
        word[SW_FREQ_OK]     = f_freq;
        word[SW_IN_OPER]     = f_start || f_fnz;
        word[SW_AUTOSTART]   = f_ovl && !st_q.trip;
        word[SW_VOLT_EXC]    = f_volt;
        word[SW_TORQ_EXC]    = f_torq;
        word[SW_TIMER_EXC]   = f_therm;
        // One register for all bits keeps the snapshot coherent
        st_d.status = f_lost ? WORD_ZERO : word;

        st_d.rdata = WORD_ZERO;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_STATUS:  st_d.rdata = st_q.status;
                ADDR_COMMAND: st_d.rdata = st_q.cmd;
                ADDR_CONFIG:  st_d.rdata = {15'h0000, st_q.profile_mode};
                default:      st_d.rdata = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q              <= '0;
            st_q.cmd          <= CMD_RESET_V;
            st_q.profile_mode <= CFG_RESET_V;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign drive_status_word = st_q.status;
    assign reg_rdata         = st_q.rdata;
    // Start refused while tripped or inhibited
    assign start_accepted    = cmd_on_all(st_q.cmd) && !st_q.trip && !st_q.inhibit;

    // Assertions
    a_link_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        f_lost |=> (drive_status_word == WORD_ZERO))
        else $error("status word not zero after link loss");
    a_trip_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_q.trip && !rst_edge) |=> st_q.trip)
        else $error("trip dropped without reset");
    a_on2_mirror: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_lost |=> (drive_status_word[SW_ON2] == $past(st_q.cmd[CW_ON2])))
        else $error("bit4 does not mirror command bit1");
    a_on3_mirror: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_lost |=> (drive_status_word[SW_ON3] == $past(st_q.cmd[CW_ON3])))
        else $error("bit5 does not mirror command bit2");
    a_ready_off: assert property (@(posedge core_clk) disable iff (!nrst)
        (!cmd_on_all(st_q.cmd) || st_q.trip) |=> !drive_status_word[SW_CTRL_READY])
        else $error("bit0 set while off or tripped");
    a_drive_ready: assert property (@(posedge core_clk) disable iff (!nrst)
        drive_status_word[SW_DRIVE_READY] |-> drive_status_word[SW_CTRL_READY])
        else $error("bit1 set without bit0");
    a_enable_bit: assert property (@(posedge core_clk) disable iff (!nrst)
        drive_status_word[SW_ENABLE] |-> !drive_status_word[SW_TRIP])
        else $error("bit2 set while tripped");
    a_invalid_ign: assert property (@(posedge core_clk) disable iff (!nrst)
        (cmd_wr && !reg_wdata[CW_DATA_VALID]) |=> $stable(st_q.cmd))
        else $error("invalid command word taken");
    a_inh_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (clr_inhibit && !set_inhibit) |=> !st_q.inhibit)
        else $error("inhibit not cleared");
    a_inh_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_q.profile_mode && set_inhibit) |=> st_q.inhibit)
        else $error("inhibit not set");
    a_oper_bit: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && (f_start || f_fnz)) |=> drive_status_word[SW_IN_OPER])
        else $error("bit11 not set while operating");
    a_read_data: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && reg_addr == ADDR_STATUS) |=> (reg_rdata == $past(st_q.status)))
        else $error("status read mismatch");
    a_rd_command: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && reg_addr == ADDR_COMMAND) |=> (reg_rdata == $past(st_q.cmd)))
        else $error("command read mismatch");
    a_rd_unmapped: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && (reg_addr != ADDR_STATUS) && (reg_addr != ADDR_COMMAND)
            && (reg_addr != ADDR_CONFIG)) |=> (reg_rdata == WORD_ZERO))
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!nrst)
        !reg_rd |=> (reg_rdata == WORD_ZERO))
        else $error("read data not zero without read");

    a_ready_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && cmd_on_all(st_q.cmd) && !st_q.trip) |=> drive_status_word[SW_CTRL_READY])
        else $error("bit0 not set while ready");
    a_power_ready: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && cmd_on_all(st_q.cmd) && !st_q.trip && f_pwr)
            |=> drive_status_word[SW_DRIVE_READY])
        else $error("bit1 not set while powered and ready");
    a_power_gone: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_pwr |=> !drive_status_word[SW_DRIVE_READY])
        else $error("bit1 set without power");
    a_enable_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && cmd_on_all(st_q.cmd) && !st_q.trip) |=> drive_status_word[SW_ENABLE])
        else $error("bit2 not set while enabled");
    a_enable_off: assert property (@(posedge core_clk) disable iff (!nrst)
        (!cmd_on_all(st_q.cmd) || st_q.trip) |=> !drive_status_word[SW_ENABLE])
        else $error("bit2 set while off or tripped");

    a_trip_set: assert property (@(posedge core_clk) disable iff (!nrst)
        f_trip |=> st_q.trip)
        else $error("trip not latched");
    a_trip_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (rst_edge && !f_trip) |=> !st_q.trip)
        else $error("trip not cleared by reset");
    a_trip_bit: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && st_q.trip) |=> drive_status_word[SW_TRIP])
        else $error("bit3 not set while tripped");
    a_trip_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        st_q.trip |-> !start_accepted)
        else $error("start accepted while tripped");
    a_inh_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        st_q.inhibit |-> !start_accepted)
        else $error("start accepted while inhibited");
    a_inh_profile: assert property (@(posedge core_clk) disable iff (!nrst)
        !st_q.profile_mode |=> !st_q.inhibit)
        else $error("inhibit set outside profile mode");
    a_valid_take: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid |=> (st_q.cmd == $past(reg_wdata)))
        else $error("valid command word not taken");

    // Level bits trail their filtered input by one cycle
    a_warn_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_warn) |=> drive_status_word[SW_WARNING])
        else $error("bit7 not set on warning");
    a_warn_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_warn |=> !drive_status_word[SW_WARNING])
        else $error("bit7 set without warning");
    a_speed_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_speed) |=> drive_status_word[SW_SPEED_MATCH])
        else $error("bit8 not set at reference");
    a_speed_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_speed |=> !drive_status_word[SW_SPEED_MATCH])
        else $error("bit8 set while deviating");
    a_bus_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && !f_stop && !f_local) |=> drive_status_word[SW_BUS_CTRL])
        else $error("bit9 not set under bus control");
    a_bus_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (f_stop || f_local) |=> !drive_status_word[SW_BUS_CTRL])
        else $error("bit9 set while local");
    a_freq_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_freq) |=> drive_status_word[SW_FREQ_OK])
        else $error("bit10 not set within limits");
    a_freq_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_freq |=> !drive_status_word[SW_FREQ_OK])
        else $error("bit10 set outside limits");
    a_oper_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_start && !f_fnz) |=> !drive_status_word[SW_IN_OPER])
        else $error("bit11 set while not turning");

    a_ovl_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_ovl && !st_q.trip) |=> drive_status_word[SW_AUTOSTART])
        else $error("bit12 not set on overload halt");
    a_ovl_trip: assert property (@(posedge core_clk) disable iff (!nrst)
        st_q.trip |=> !drive_status_word[SW_AUTOSTART])
        else $error("bit12 set while tripped");
    a_ovl_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_ovl |=> !drive_status_word[SW_AUTOSTART])
        else $error("bit12 set after overload ended");
    a_volt_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_volt) |=> drive_status_word[SW_VOLT_EXC])
        else $error("bit13 not set on voltage fault");
    a_volt_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_volt |=> !drive_status_word[SW_VOLT_EXC])
        else $error("bit13 set without voltage fault");
    a_torq_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_torq) |=> drive_status_word[SW_TORQ_EXC])
        else $error("bit14 not set over torque limit");
    a_torq_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_torq |=> !drive_status_word[SW_TORQ_EXC])
        else $error("bit14 set below torque limits");
    a_therm_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (!f_lost && f_therm) |=> drive_status_word[SW_TIMER_EXC])
        else $error("bit15 not set on thermal timer");
    a_therm_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        !f_therm |=> !drive_status_word[SW_TIMER_EXC])
        else $error("bit15 set without thermal timer");

    c_trip_seen:   cover property (@(posedge core_clk) disable iff (!nrst) st_q.trip);
    c_trip_reset:  cover property (@(posedge core_clk) disable iff (!nrst)
        st_q.trip ##1 !st_q.trip);
    c_inh_cleared: cover property (@(posedge core_clk) disable iff (!nrst)
        st_q.inhibit ##1 !st_q.inhibit);
    c_ready:       cover property (@(posedge core_clk) disable iff (!nrst)
        drive_status_word[SW_DRIVE_READY]);
    c_profile_off: cover property (@(posedge core_clk) disable iff (!nrst) !st_q.profile_mode);

endmodule // dswb_top

/* File: verif/dswb_bus_master.sv */
`timescale 1ns/1ns
// Fieldbus master: reads any register, its status word writes are ignored, owns the command word
module dswb_bus_master
(
    // Clock
    input  wire logic        clk,
    // Register port
    output logic      [7:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    initial
    begin
        addr  = 8'h00;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_word(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
endmodule // dswb_bus_master

/* File: verif/drive_status_word_builder_tb_top.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("mismatch %s exp %h got %h", n, e, g); \
        end \
    end
module drive_status_word_builder_tb_top;
    import dswb_pkg::*;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    // Supervision pins, power present from the start
    logic [13:0] sv       = 14'h0002;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [15:0] drive_status_word;
    logic        reg_wr;
    logic        reg_rd;
    logic        start_accepted;
    int          miscompares = 0;
    int          checks_done = 0;

    always #25 core_clk = ~core_clk;

    dswb_top DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trip_event(sv[0]), .power_supplied(sv[1]), .warning_any(sv[2]),
        .speed_at_ref(sv[3]), .panel_stop(sv[4]), .local_ref_site(sv[5]),
        .freq_in_limits(sv[6]), .start_cmd(sv[7]), .freq_nonzero(sv[8]),
        .overload_halt(sv[9]), .dc_volt_fault(sv[10]), .torque_exceeded(sv[11]),
        .thermal_exceeded(sv[12]), .link_lost(sv[13]),
        .drive_status_word(drive_status_word), .start_accepted(start_accepted));

    dswb_bus_master m (.clk(core_clk), .addr(reg_addr), .wdata(reg_wdata),
        .wr(reg_wr), .rd(reg_rd), .rdata(reg_rdata));

    task automatic end_of_test();
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        m.wr_word(a, d);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("status", e, drive_status_word)
    endtask

    // Pin path takes five cycles through sync and filter
    task automatic pin(input int i, input logic v, input logic [15:0] e);
        @(posedge core_clk);
        sv[i] <= v;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("status", e, drive_status_word)
    endtask

    task automatic rearm();
        cmd(ADDR_COMMAND, 16'h0406, 16'h0230);
        cmd(ADDR_COMMAND, 16'h0407, 16'h0237);
    endtask

    task automatic t_regs();
        logic [15:0] r;
        m.rd_word(ADDR_STATUS, r);
        `CHK("rd status", 16'h0240, r)
        m.rd_word(ADDR_CONFIG, r);
        `CHK("rd config", 16'h0001, r)
        m.rd_word(8'h0c, r);
        `CHK("rd unmapped", 16'h0000, r)
        cmd(ADDR_STATUS, 16'hffff, 16'h0240);
    endtask

    task automatic t_commands();
        logic [15:0] r;
        rearm();
        `CHK("start ok", 1'b1, start_accepted)
        cmd(ADDR_COMMAND, 16'h0003, 16'h0237);
        m.rd_word(ADDR_COMMAND, r);
        `CHK("rd command", 16'h0407, r)
        cmd(ADDR_COMMAND, 16'h0405, 16'h0260);
        rearm();
        cmd(ADDR_COMMAND, 16'h0403, 16'h0250);
        rearm();
        pin(1, 1'b0, 16'h0235);
        pin(1, 1'b1, 16'h0277);
        `CHK("start ok", 1'b0, start_accepted)
        rearm();
    endtask

    task automatic t_inputs();
        int p[11] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12};
        logic [15:0] e[11] = '{16'h02b7, 16'h0337, 16'h0037, 16'h0037, 16'h0637,
            16'h0a37, 16'h0a37, 16'h1237, 16'h2237, 16'h4237, 16'h8237};
        for (int k = 0; k < 11; k++)
        begin
            pin(p[k], 1'b1, e[k]);
            pin(p[k], 1'b0, 16'h0237);
        end
    endtask

    task automatic t_trip();
        pin(0, 1'b1, 16'h0238);
        `CHK("start ok", 1'b0, start_accepted)
        pin(9, 1'b1, 16'h0238);
        pin(9, 1'b0, 16'h0238);
        pin(0, 1'b0, 16'h0238);
        cmd(ADDR_COMMAND, 16'h0487, 16'h0277);
        rearm();
    endtask

    task automatic t_profile_link();
        logic [15:0] r;
        m.wr_word(ADDR_CONFIG, 16'h0000);
        cmd(ADDR_COMMAND, 16'h0405, 16'h0220);
        m.wr_word(ADDR_CONFIG, 16'h0001);
        cmd(ADDR_COMMAND, 16'h0407, 16'h0237);
        pin(13, 1'b1, 16'h0000);
        m.rd_word(ADDR_STATUS, r);
        `CHK("rd status", 16'h0000, r)
        pin(13, 1'b0, 16'h0237);
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("status", 16'h0240, drive_status_word)
        t_regs();
        t_commands();
        t_inputs();
        t_trip();
        t_profile_link();
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end
endmodule // drive_status_word_builder_tb_top
